// ---- core/win_pkg.sv ----
// Constants and carrier types for the SDRAM window decoder.
// Assumes a host address of 21 bits (2 MByte chip-select space) and a 32-bit data path.
package win_pkg;

  localparam int unsigned ADDR_W = 21;
  localparam int unsigned MEM_AW = 23;
  localparam int unsigned DATA_W = 32;
  // Register space: four 64 kByte regions, 256 kByte in all.
  localparam logic [20:0] REG_SPACE_END = 21'h040000;
  localparam logic [20:0] CS_SPACE_END = 21'h200000;
  // Word-only FIFO locations inside each register region.
  localparam logic [15:0] IN_FIFO_OFS = 16'h0004;
  localparam logic [15:0] OUT_FIFO_OFS = 16'h0008;
  // Reset values of the completion flag and the ready output.
  localparam logic WDONE_RESET = 1'b1;
  localparam logic READY_RESET = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_HOLD = 2'b11
  } access_state_t;

  typedef struct packed {
    logic [20:0] host_base;
    logic [20:0] length;
    logic [22:0] mem_base;
  } win_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [22:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } mem_req_t;

endpackage : win_pkg

// ---- core/win_match.sv ----
// One window comparator: hit test and physical address translation.
// Assumes the window configuration is stable while accesses are in progress.
`timescale 1ns/1ps
module win_match (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [20:0] host_addr,
  input wire win_pkg::win_cfg_t cfg,
  output logic hit_r,
  output logic [22:0] phys_r
);

  logic [21:0] offs;
  logic hit_nxt;
  logic [22:0] phys_nxt;

  // Offset from the window base; the extra bit catches addresses below base.
  always_comb begin
    offs = {1'b0, host_addr} - {1'b0, cfg.host_base};
    hit_nxt = !offs[21] && (offs[20:0] < cfg.length);
    phys_nxt = cfg.mem_base + {2'b00, offs[20:0]};
  end

  // Registered so the decode path stays short at 125 MHz.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hit_r <= 1'b0;
      phys_r <= '0;
    end else begin
      hit_r <= hit_nxt;
      phys_r <= phys_nxt;
    end
  end

endmodule : win_match

// ---- core/sdram_window_decoder.sv ----
// Host chip-select decoder with direct physical SDRAM window access.
// Assumes the host bus is synchronous to core_clk and holds its strobes until served.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Two independent SDRAM windows per controller.
// - Windows idle until SDRAM space enabled.
// - Window has host base, length, memory base.
// - Windows live in 1.75 MByte above registers.
// - Unmapped SDRAM space: no read data, writes dropped.
// - Empty reads raise empty flag, bus undriven.
// - Overlapping own windows resolved by fixed priority.
// - Writes accepted wherever own window maps address.
// - Window path uses physical addresses only.
// - Consecutive host addresses map consecutively.
// - Window accesses go through shared arbiter.
// - Reads hold ready low until data arrives.
// - Writes report completion via done flag.
// - Write sizes any; external variant reads words only.
// - FIFO locations take word accesses only.
// - Width pin selects 32- or 16-bit bus.
// - Big-endian lanes; strobes give write size.
// - Reads drive the full bus width.
// - Register region chosen by two mode pins.
// - Register space decode beats window decode.
module sdram_window_decoder #(
  parameter bit EXT_SDRAM = 1'b0
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic host_chip_select_n,
  input wire logic host_read_strobe_n,
  input wire logic [3:0] byte_lane_write_strobes_n,
  input wire logic [20:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic bus_32bit_mode,
  input wire logic [1:0] region_select,
  input wire logic sdram_space_enable,
  input wire win_pkg::win_cfg_t win0_cfg,
  input wire win_pkg::win_cfg_t win1_cfg,
  input wire logic arb_grant,
  input wire logic arb_rvalid,
  input wire logic [31:0] arb_rdata,
  input wire logic arb_wdone,
  output logic host_ready,
  output logic [31:0] host_rdata,
  output logic host_data_oe,
  output logic read_empty,
  output logic reg_hit,
  output logic fifo_size_error,
  output logic window_write_done_flag,
  output win_pkg::mem_req_t mem_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Access detection.

  logic rd_act;
  logic wr_act;
  logic w0_hit;
  logic w1_hit;
  logic [22:0] w0_phys;
  logic [22:0] w1_phys;
  logic [20:0] lane_addr;

  assign rd_act = !host_chip_select_n && !host_read_strobe_n;
  assign wr_act = !host_chip_select_n && (byte_lane_write_strobes_n != 4'hf);
  // In 16-bit mode the upper write strobes are pulled high, so only lanes 0 and 1 count.
  assign lane_addr = host_addr;

  // One comparator per window, repeated by a generate loop.
  win_pkg::win_cfg_t cfg_arr [2];
  logic [1:0] hit_v;
  logic [22:0] phys_v [2];
  assign cfg_arr[0] = win0_cfg;
  assign cfg_arr[1] = win1_cfg;
  for (genvar gi = 0; gi < 2; gi++) begin : g_win
    win_match u_match (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .host_addr(lane_addr),
      .cfg(cfg_arr[gi]),
      .hit_r(hit_v[gi]),
      .phys_r(phys_v[gi])
    );
  end
  assign w0_hit = hit_v[0];
  assign w1_hit = hit_v[1];
  assign w0_phys = phys_v[0];
  assign w1_phys = phys_v[1];

  ////////////////////////////////////////////////////////////////////////////
  // Address classification; evaluated once the registered comparators settle.

  logic in_reg_space;
  logic own_region;
  logic in_fifo;
  logic win_sel;
  logic win_any;
  logic [22:0] sel_phys;
  logic word_access;
  logic read_size_ok;

  always_comb begin
    in_reg_space = host_addr < win_pkg::REG_SPACE_END;
    own_region = in_reg_space && (host_addr[17:16] == region_select);
    in_fifo = own_region && ((host_addr[15:0] & 16'hfffc) == win_pkg::IN_FIFO_OFS
      || (host_addr[15:0] & 16'hfffc) == win_pkg::OUT_FIFO_OFS);
    // Window space starts above all four register regions.
    win_any = sdram_space_enable && !in_reg_space && (w0_hit || w1_hit);
    win_sel = w1_hit;
    sel_phys = win_sel ? w1_phys : w0_phys;
    // Word access: all four strobes in 32-bit mode; address check for reads.
    word_access = bus_32bit_mode ? (byte_lane_write_strobes_n == 4'h0)
      : (byte_lane_write_strobes_n[1:0] == 2'b00);
    read_size_ok = !EXT_SDRAM || (host_addr[1:0] == 2'b00);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direct access state machine.

  win_pkg::access_state_t state_r, state_nxt;
  logic ready_r, ready_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic oe_r, oe_nxt;
  logic empty_r, empty_nxt;
  logic reg_hit_r, reg_hit_nxt;
  logic ferr_r, ferr_nxt;
  logic wdone_r, wdone_nxt;
  logic settle_r, settle_nxt;
  win_pkg::mem_req_t req_r, req_nxt;

  // The decode takes one cycle to settle before an access is classified.
  always_comb begin
    state_nxt = state_r;
    ready_nxt = ready_r;
    rdata_nxt = rdata_r;
    oe_nxt = oe_r;
    empty_nxt = 1'b0;
    reg_hit_nxt = 1'b0;
    ferr_nxt = 1'b0;
    wdone_nxt = wdone_r;
    settle_nxt = 1'b0;
    req_nxt = req_r;
    if (arb_wdone) begin
      wdone_nxt = 1'b1;
    end
    case (state_r)
      win_pkg::ST_IDLE: begin
        oe_nxt = 1'b0;
        ready_nxt = 1'b1;
        if ((rd_act || wr_act) && !settle_r) begin
          settle_nxt = 1'b1;
          ready_nxt = !rd_act;
        end else if ((rd_act || wr_act) && settle_r) begin
          reg_hit_nxt = own_region;
          ferr_nxt = in_fifo && wr_act && !word_access;
          if (win_any && rd_act && read_size_ok) begin
            req_nxt = '{valid: 1'b1, write: 1'b0, addr: sel_phys, be: 4'hf,
              wdata: 32'h0};
            ready_nxt = 1'b0;
            state_nxt = win_pkg::ST_READ;
          end else if (win_any && wr_act) begin
            req_nxt = '{valid: 1'b1, write: 1'b1, addr: sel_phys,
              be: ~byte_lane_write_strobes_n, wdata: host_wdata};
            wdone_nxt = 1'b0;
            state_nxt = win_pkg::ST_WRITE;
          end else begin
            // Gaps, foreign windows and refused sizes: nothing driven, writes dropped.
            empty_nxt = rd_act && !in_reg_space;
            ready_nxt = 1'b1;
            state_nxt = win_pkg::ST_HOLD;
          end
        end
      end
      win_pkg::ST_READ: begin
        ready_nxt = 1'b0;
        if (arb_grant) begin
          req_nxt.valid = 1'b0;
        end
        if (arb_rvalid) begin
          rdata_nxt = arb_rdata;
          oe_nxt = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = win_pkg::ST_HOLD;
        end
      end
      win_pkg::ST_WRITE: begin
        if (arb_grant) begin
          req_nxt.valid = 1'b0;
          state_nxt = win_pkg::ST_HOLD;
        end
      end
      win_pkg::ST_HOLD: begin
        // Wait for the host to drop its strobes so one access is served once.
        empty_nxt = empty_r && rd_act;
        if (!rd_act && !wr_act) begin
          oe_nxt = 1'b0;
          state_nxt = win_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = win_pkg::ST_IDLE;
      end
    endcase
  end

  // Registers of the access machine; all outputs come from here.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= win_pkg::ST_IDLE;
      ready_r <= win_pkg::READY_RESET;
      rdata_r <= '0;
      oe_r <= 1'b0;
      empty_r <= 1'b0;
      reg_hit_r <= 1'b0;
      ferr_r <= 1'b0;
      wdone_r <= win_pkg::WDONE_RESET;
      settle_r <= 1'b0;
      req_r <= '0;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
      oe_r <= oe_nxt;
      empty_r <= empty_nxt;
      reg_hit_r <= reg_hit_nxt;
      ferr_r <= ferr_nxt;
      wdone_r <= wdone_nxt;
      settle_r <= settle_nxt;
      req_r <= req_nxt;
    end
  end

  assign host_ready = ready_r;
  assign host_rdata = rdata_r;
  assign host_data_oe = oe_r;
  assign read_empty = empty_r;
  assign reg_hit = reg_hit_r;
  assign fifo_size_error = ferr_r;
  assign window_write_done_flag = wdone_r;
  assign mem_req = req_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_empty_undriven: assert property (@(posedge core_clk) disable iff (!arst_n)
    read_empty |-> !host_data_oe) else $error("data driven during empty read");
  a_disabled_silent: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE && !sdram_space_enable) |=> !mem_req.valid)
    else $error("window access while space disabled");
  a_read_ready_low: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_READ && !arb_rvalid) |=> !host_ready)
    else $error("ready raised before read data");
  a_read_ready_up: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_READ && arb_rvalid) |=> host_ready && host_data_oe
      && host_rdata == $past(arb_rdata)) else $error("read data not returned");
  a_wdone_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(mem_req.valid) && mem_req.write && !$past(arb_wdone) |-> !window_write_done_flag)
    else $error("done flag not cleared on write");
  a_wdone_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    arb_wdone |=> window_write_done_flag) else $error("done flag not set");
  a_win_prio: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE && settle_r && win_any && w1_hit && (rd_act || wr_act))
    |=> mem_req.addr == $past(w1_phys)) else $error("window priority wrong");
  a_reg_first: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE && settle_r && in_reg_space) |=> !mem_req.valid)
    else $error("window hit over register space");
  a_write_lanes: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(mem_req.valid) && mem_req.write |-> mem_req.be == ~$past(byte_lane_write_strobes_n))
    else $error("byte lanes wrong");
  // Partial FIFO writes and empty reads must be flagged, window accesses issued and held until grant, finished accesses must release the bus.
  a_fifo_word: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE && settle_r && wr_act && in_fifo && !word_access)
    |=> fifo_size_error) else $error("partial FIFO write not flagged");
  a_empty_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE && settle_r && rd_act && !win_any && !in_reg_space)
    |=> read_empty && host_ready && !mem_req.valid) else $error("empty read not refused");
  a_reg_region: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE && settle_r && (rd_act || wr_act))
    |=> reg_hit == ($past(host_addr) < win_pkg::REG_SPACE_END
      && $past(host_addr[17:16]) == $past(region_select))) else $error("region decode wrong");
  a_req_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mem_req.valid && !arb_grant) |=> mem_req.valid && $stable(mem_req.addr))
    else $error("request dropped before grant");
  a_req_drop: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mem_req.valid && arb_grant) |=> !mem_req.valid)
    else $error("request held after grant");
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE) |-> !host_data_oe) else $error("data driven while idle");
  a_read_issue: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE && settle_r && win_any && rd_act && read_size_ok)
    |=> !host_ready && mem_req.valid && !mem_req.write) else $error("window read not issued");
  a_write_issue: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_IDLE && settle_r && win_any && wr_act) |=> mem_req.valid
      && mem_req.write && mem_req.wdata == $past(host_wdata)) else $error("write not issued");
  a_hold_release: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == win_pkg::ST_HOLD && !rd_act && !wr_act)
    |=> state_r == win_pkg::ST_IDLE && !host_data_oe) else $error("bus not released");

endmodule : sdram_window_decoder

// ---- tb/arb_model.sv ----
// Arbiter stand-in: grants, answers and completes decoder requests late.
// Assumes one outstanding request at a time from the decoder.
`timescale 1ns/1ps
module arb_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire win_pkg::mem_req_t mem_req,
  output logic arb_grant,
  output logic arb_rvalid,
  output logic [31:0] arb_rdata,
  output logic arb_wdone,
  output logic req_seen,
  output win_pkg::mem_req_t req_taken
);
  // Outputs start quiet so the decoder never sees a stray grant; one process owns them.
  // Random waits stand for other requesters; idle data is junk, not the last word.
  initial begin
    {arb_grant, arb_rvalid, arb_wdone, req_seen} = 4'h0;
    arb_rdata = 32'h0;
    req_taken = '0;
    forever begin
      @(posedge core_clk);
      if (arst_n && mem_req.valid) begin
        repeat ($urandom_range(4)) @(posedge core_clk);
        arb_grant <= 1'b1;
        req_seen <= 1'b1;
        req_taken <= mem_req;
        @(posedge core_clk);
        {arb_grant, req_seen} <= 2'h0;
        repeat ($urandom_range(6, 1)) @(posedge core_clk);
        if (req_taken.write) arb_wdone <= 1'b1;
        else arb_rvalid <= 1'b1;
        arb_rdata <= {9'h1a5, req_taken.addr};
        @(posedge core_clk);
        {arb_wdone, arb_rvalid} <= 2'h0;
        arb_rdata <= ~arb_rdata;
      end
    end
  end
endmodule : arb_model

// ---- tb/sdram_window_decoder_tb_top.sv ----
// Bench for the window decoder: host driver, result monitor, arbiter model.
// Assumes the arbiter model is compiled before this file.
`timescale 1ns/1ps
module sdram_window_decoder_tb_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic [3:0] wr_n = 4'hf;
  logic [20:0] addr = 21'h0;
  logic [31:0] wdata = 32'h0;
  logic space_en = 1'b0;
  win_pkg::win_cfg_t w0 = {21'h040000, 21'h010000, 23'h100000};
  win_pkg::win_cfg_t w1 = {21'h048000, 21'h010000, 23'h300000};
  logic grant, rvalid, wdone, ready, oe, empty, reg_hit, ferr, flag, seen;
  logic [31:0] rdata, mrdata;
  win_pkg::mem_req_t req, taken;
  win_pkg::mem_req_t exp_req[$];
  logic [31:0] exp_rd[$];
  int bad_count = 0;
  int n_checks = 0;
  logic prev_rdy = 1'b1;
  logic mode32 = 1'b1;
  logic [1:0] region = 2'h1;
  int reg_cnt = 0;
  int ferr_cnt = 0;

  always #4 core_clk = ~core_clk;

  sdram_window_decoder i_sdram_window_decoder (.core_clk(core_clk), .arst_n(arst_n),
    .host_chip_select_n(cs_n), .host_read_strobe_n(rd_n), .byte_lane_write_strobes_n(wr_n),
    .host_addr(addr), .host_wdata(wdata), .bus_32bit_mode(mode32), .region_select(region),
    .sdram_space_enable(space_en), .win0_cfg(w0), .win1_cfg(w1), .arb_grant(grant),
    .arb_rvalid(rvalid), .arb_rdata(mrdata), .arb_wdone(wdone), .host_ready(ready),
    .host_rdata(rdata), .host_data_oe(oe), .read_empty(empty), .reg_hit(reg_hit),
    .fifo_size_error(ferr), .window_write_done_flag(flag), .mem_req(req));
  arb_model i_arb_model (.core_clk(core_clk), .arst_n(arst_n), .mem_req(req),
    .arb_grant(grant), .arb_rvalid(rvalid), .arb_rdata(mrdata), .arb_wdone(wdone),
    .req_seen(seen), .req_taken(taken));

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks, one for each kind of result.
  task automatic chk_bit(input logic got, input logic want);
    n_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, want);
    end
  endtask : chk_bit

  task automatic chk_req(input win_pkg::mem_req_t got, input win_pkg::mem_req_t want);
    n_checks++;
    if (got.write !== want.write || got.addr !== want.addr ||
        (want.write && {got.be, got.wdata} !== {want.be, want.wdata})) begin
      bad_count++;
      $display("wrong value at %0t: memory request %h, expected %h", $time, got, want);
    end
  endtask : chk_req

  task automatic chk_word(input logic [31:0] got, input logic got_oe, input logic [31:0] want);
    n_checks++;
    if (got !== want || got_oe !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: read data %h, expected %h", $time, got, want);
    end
  endtask : chk_word

  task automatic conclude;
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////
  // One host access; x is the expected empty bit (read) or untouched flag (write).
  task automatic access(input logic wr, input logic [20:0] a, input logic [3:0] s_n,
                        input logic [31:0] d, input logic x, input logic hit,
                        input logic [22:0] phys);
    int i;
    if (hit) exp_req.push_back('{1'b1, wr, phys, ~s_n, d});
    if (hit && !wr) exp_rd.push_back({9'h1a5, phys});
    @(posedge core_clk);
    cs_n <= 1'b0;
    addr <= a;
    wdata <= d;
    if (wr) wr_n <= s_n;
    else rd_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk_bit(wr ? flag : empty, x);
    // The host waits on ready for reads and polls the done flag for writes.
    for (i = 0; i < 300 && (wr ? flag : ready) !== 1'b1; i++) @(posedge core_clk);
    chk_bit(wr ? flag : ready, 1'b1);
    @(posedge core_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 4'hf;
    addr <= ~a;
    @(posedge core_clk);
  endtask : access

  // Monitor: each granted request and each finished read takes the oldest note.
  always @(posedge core_clk) begin
    if (seen && exp_req.size() == 0) chk_bit(seen, 1'b0);
    else if (seen) chk_req(taken, exp_req.pop_front());
    // Only window reads return data; refused reads raise ready with nothing noted.
    if (ready && !prev_rdy && exp_rd.size() > 0) begin
      chk_word(rdata, oe, exp_rd.pop_front());
    end
    prev_rdy <= ready;
    if (reg_hit) reg_cnt <= reg_cnt + 1;
    if (ferr) ferr_cnt <= ferr_cnt + 1;
  end

  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; no read ever targets another controller's window.
  initial begin
    int i;
    logic [20:0] ofs;
    logic [3:0] lanes [7] = '{4'h0, 4'h3, 4'hc, 4'h7, 4'hb, 4'hd, 4'he};
    void'($urandom(9));
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    access(1'b0, 21'h040100, 4'hf, 32'h0, 1'b1, 1'b0, 23'h0);
    space_en <= 1'b1;
    for (i = 0; i < 4; i++) begin
      ofs = 21'($urandom_range(32764)) & 21'h007ffc;
      access(1'b0, 21'h040000 + ofs, 4'hf, 32'h0, 1'b0, 1'b1, 23'h100000 + 23'(ofs));
    end
    access(1'b0, 21'h048010, 4'hf, 32'h0, 1'b0, 1'b1, 23'h300010);
    access(1'b0, 21'h057ffc, 4'hf, 32'h0, 1'b0, 1'b1, 23'h30fffc);
    access(1'b0, 21'h058000, 4'hf, 32'h0, 1'b1, 1'b0, 23'h0);
    for (i = 0; i < 7; i++) begin
      ofs = 21'($urandom_range(32764));
      access(1'b1, 21'h040000 + ofs, lanes[i], $urandom, 1'b0, 1'b1,
             23'h100000 + 23'(ofs));
    end
    access(1'b1, 21'h060000, 4'h0, $urandom, 1'b1, 1'b0, 23'h0);
    i = ferr_cnt;
    access(1'b1, 21'h010004, 4'h0, $urandom, 1'b1, 1'b0, 23'h0);
    chk_bit(ferr_cnt != i, 1'b0);
    access(1'b1, 21'h010008, 4'hc, $urandom, 1'b1, 1'b0, 23'h0);
    chk_bit(ferr_cnt != i, 1'b1);
    // In 16-bit mode a lane 0/1 pair is a whole FIFO word; a single lane is not.
    mode32 <= 1'b0;
    i = ferr_cnt;
    access(1'b1, 21'h010004, 4'hc, $urandom, 1'b1, 1'b0, 23'h0);
    chk_bit(ferr_cnt != i, 1'b0);
    access(1'b1, 21'h010004, 4'hd, $urandom, 1'b1, 1'b0, 23'h0);
    chk_bit(ferr_cnt != i, 1'b1);
    access(1'b1, 21'h040200, 4'hc, $urandom, 1'b0, 1'b1, 23'h100200);
    mode32 <= 1'b1;
    // Window 0 laid over register region 1 must lose to the register decode.
    w0.host_base <= 21'h010000;
    i = reg_cnt;
    access(1'b0, 21'h010020, 4'hf, 32'h0, 1'b0, 1'b0, 23'h0);
    chk_bit(reg_cnt != i, 1'b1);
    region <= 2'h2;
    i = reg_cnt;
    access(1'b0, 21'h010020, 4'hf, 32'h0, 1'b0, 1'b0, 23'h0);
    chk_bit(reg_cnt != i, 1'b0);
    chk_bit(exp_req.size() == 0 && exp_rd.size() == 0, 1'b1);
    conclude();
  end
endmodule : sdram_window_decoder_tb_top
